//--- core/ldpc_pkg.sv
// Shared constants, types and timing for the LED dimming pulse control block.
// Assumes a single 40 MHz system clock; all pin timing is converted to cycles here.
package ldpc_pkg;

	////////////////////////////////////////////////////////////////////////////////
	// Clock and timing
	localparam int unsigned CLK_HZ          = 40_000_000;
	localparam int unsigned CYC_PER_US      = CLK_HZ / 1_000_000;
	localparam int unsigned SHDN_TIME_US    = 20_000;  // Low time to shutdown, typical
	localparam int unsigned SHDN_MIN_US     = 12_500;  // Must not trip earlier
	localparam int unsigned SHDN_MAX_US     = 30_000;  // Must trip by then
	localparam int unsigned SHDN_CYCLES     = SHDN_TIME_US * CYC_PER_US;
	localparam int unsigned SHDN_MIN_CYCLES = (SHDN_MIN_US * CYC_PER_US) + 1;
	localparam int unsigned SHDN_MAX_CYCLES = SHDN_MAX_US * CYC_PER_US;
	localparam int unsigned TIMER_W         = 20;
	localparam int unsigned PUMP_DWELL      = 64;      // Settle cycles before a further gain step

	////////////////////////////////////////////////////////////////////////////////
	// Dimming and channels
	localparam int unsigned CHANNELS        = 6;
	localparam int unsigned COUNT_W         = 5;
	localparam int unsigned LEVEL_W         = 6;
	localparam logic [LEVEL_W-1:0] LEVEL_FULL = 6'h20;  // 32/32 of full scale
	localparam logic [COUNT_W-1:0] COUNT_RST  = 5'h00;
	localparam logic [COUNT_W-1:0] COUNT_LAST = 5'h1f;

	////////////////////////////////////////////////////////////////////////////////
	// Types
	typedef enum logic [1:0] {
		LDPC_PUMP_1X,
		LDPC_PUMP_1X33,
		LDPC_PUMP_1X5,
		LDPC_PUMP_2X
	} ldpc_pump_mode_t;

	// Asynchronous pin and comparator levels, carried together through the synchroniser
	typedef struct packed {
		logic dim_pulse;     // Dimming pulse input, active high
		logic pwm_gate;      // PWM gate input, active high
		logic supply_low;    // Supply below undervoltage threshold
		logic reg_short;     // Some channel can no longer be regulated
		logic unity_ok;      // Supply sufficient for unity gain, hysteresis applied
	} ldpc_pins_t;

	typedef struct packed {
		ldpc_pins_t                 sync1;
		ldpc_pins_t                 sync2;
		logic                       dim_prev;
		logic                       enabled;
		logic [COUNT_W-1:0]         count;
		logic [TIMER_W-1:0]         dim_low;
		logic [TIMER_W-1:0]         pwm_low;
		logic [CHANNELS-1:0]        sink_en;
		logic [CHANNELS-1:0]        sink_hiz;
		logic [LEVEL_W-1:0]         level;
	} ldpc_state_t;

	typedef struct packed {
		ldpc_pump_mode_t            mode;
		logic [7:0]                 dwell;
	} ldpc_pump_state_t;

endpackage

//--- core/ldpc_pump_seq.sv
// Charge pump gain sequencer: steps up one gain at a time, drops straight to unity.
// Assumes its level inputs are already synchronised to i_clk_sys.
module ldpc_pump_seq #(
	parameter int unsigned P_DWELL = ldpc_pkg::PUMP_DWELL
) (
	input  wire logic                   i_clk_sys,
	input  wire logic                   i_rst_n,
	input  wire logic                   i_run,
	input  wire logic                   i_reg_short,
	input  wire logic                   i_unity_ok,
	output ldpc_pkg::ldpc_pump_mode_t   o_mode
);

	if (P_DWELL < 1 || P_DWELL > 255) begin : g_chk
		$error("P_DWELL must be 1..255");
	end

	localparam logic [7:0] DWELL_LAST = 8'(P_DWELL - 1);

	ldpc_pkg::ldpc_pump_state_t st;
	ldpc_pkg::ldpc_pump_state_t next_st;

	////////////////////////////////////////////////////////////////////////////////
	// Next mode; the dwell keeps one short report from skipping several gains
	always_comb begin
		next_st = st;
		if (st.dwell != 8'h00) begin
			next_st.dwell = st.dwell - 8'h01;
		end
		if (!i_run) begin
			next_st.mode  = ldpc_pkg::LDPC_PUMP_1X;
			next_st.dwell = 8'h00;
		end else if (i_unity_ok && st.mode != ldpc_pkg::LDPC_PUMP_1X) begin
			next_st.mode  = ldpc_pkg::LDPC_PUMP_1X;  // Never via an intermediate gain
			next_st.dwell = DWELL_LAST;
		end else if (i_reg_short && !i_unity_ok && st.dwell == 8'h00) begin
			next_st.dwell = DWELL_LAST;
			case (st.mode)  // One gain step at a time
				ldpc_pkg::LDPC_PUMP_1X:   next_st.mode = ldpc_pkg::LDPC_PUMP_1X33;
				ldpc_pkg::LDPC_PUMP_1X33: next_st.mode = ldpc_pkg::LDPC_PUMP_1X5;
				ldpc_pkg::LDPC_PUMP_1X5:  next_st.mode = ldpc_pkg::LDPC_PUMP_2X;
				default:                  next_st.mode = ldpc_pkg::LDPC_PUMP_2X;
			endcase
		end
	end

	always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
		if (!i_rst_n) begin
			st <= '{mode: ldpc_pkg::LDPC_PUMP_1X, dwell: 8'h00};
		end else begin
			st <= next_st;
		end
	end

	assign o_mode = st.mode;

	////////////////////////////////////////////////////////////////////////////////
	// Checks
	default clocking cb @(posedge i_clk_sys); endclocking
	default disable iff (!i_rst_n);

	a_idle_unity: assert property (!i_run |=> o_mode == ldpc_pkg::LDPC_PUMP_1X)
		else $error("pump not at unity while idle");
	a_unity_hold: assert property (o_mode == ldpc_pkg::LDPC_PUMP_1X && !i_reg_short
		|=> o_mode == ldpc_pkg::LDPC_PUMP_1X)
		else $error("left unity without regulation loss");
	a_step_to_1x5: assert property ($changed(o_mode) && o_mode == ldpc_pkg::LDPC_PUMP_1X5
		|-> $past(o_mode) == ldpc_pkg::LDPC_PUMP_1X33)
		else $error("1.5x not entered from 1.33x");
	a_step_to_2x: assert property ($changed(o_mode) && o_mode == ldpc_pkg::LDPC_PUMP_2X
		|-> $past(o_mode) == ldpc_pkg::LDPC_PUMP_1X5)
		else $error("2x not entered from 1.5x");
	a_unity_return: assert property (i_run && i_unity_ok |=> o_mode == ldpc_pkg::LDPC_PUMP_1X)
		else $error("no direct return to unity");
	c_reach_2x: cover property (o_mode == ldpc_pkg::LDPC_PUMP_2X);

endmodule

//--- core/ldpc_top.sv
// LED dimming pulse control: enable, 32-level pulse dimming, PWM gating, shutdown.
// Assumes pins and analog comparator flags arrive asynchronously to i_clk_sys.
// Channel sinks themselves are analog; this block drives their enable and level code.

// Notes on behaviour
// - Pump starts in unity gain and stays while all channels regulate.
// - On regulation loss pump steps 1.33x, then 1.5x, then 2x.
// - Sufficient supply returns pump straight to unity; hysteresis about 300 mV.
// - Supply below undervoltage threshold disables all sinks and shuts down.
// - First dimming rising edge after reset or shutdown enables at full scale.
// - Each later rising edge adds one to n; level is (32 - n)/32.
// - After 31 pulses level is lowest; next edge wraps back to full scale.
// - Dimming count holds pulses since enable and clears on each enable.
// - PWM high passes programmed level to all six channels; low gives zero.
// - Either input low for the shutdown interval forces zero-current shutdown.
// - In shutdown every sink output is high impedance with zero current.
// - Dimming and PWM inputs are both active high.
// - Dimming phases last at least 0.2 us; low phase at most 2000 us.
// - Low-time shutdown trips no earlier than 12.5 ms, no later than 30 ms.
module ldpc_top #(
	parameter int unsigned P_SHDN_CYCLES = ldpc_pkg::SHDN_CYCLES,
	parameter int unsigned P_PUMP_DWELL  = ldpc_pkg::PUMP_DWELL
) (
	input  wire logic                                i_clk_sys,
	input  wire logic                                i_rst_n,
	input  wire logic                                i_dim_pulse,
	input  wire logic                                i_pwm_gate,
	input  wire logic                                i_supply_low,
	input  wire logic                                i_reg_short,
	input  wire logic                                i_unity_ok,
	output logic                                     o_enabled,
	output logic [ldpc_pkg::LEVEL_W-1:0]             o_level,
	output logic [ldpc_pkg::CHANNELS-1:0]            o_sink_en,
	output logic [ldpc_pkg::CHANNELS-1:0]            o_sink_hiz,
	output ldpc_pkg::ldpc_pump_mode_t                o_pump_mode
);

	////////////////////////////////////////////////////////////////////////////////
	// Elaboration checks
	// A small value is allowed so simulation can shorten the timeout
	if (P_SHDN_CYCLES < 2 || P_SHDN_CYCLES > ldpc_pkg::SHDN_MAX_CYCLES
		|| P_SHDN_CYCLES >= (1 << ldpc_pkg::TIMER_W)) begin : g_chk
		$error("P_SHDN_CYCLES out of range");
	end

	localparam logic [ldpc_pkg::TIMER_W-1:0] SHDN_LAST = ldpc_pkg::TIMER_W'(P_SHDN_CYCLES - 1);
	localparam logic [ldpc_pkg::TIMER_W-1:0] TIMER_RST = '0;

	ldpc_pkg::ldpc_state_t st;
	ldpc_pkg::ldpc_state_t next_st;
	ldpc_pkg::ldpc_pins_t  pins;
	logic                  dim_rise;
	logic                  low_trip;

	assign pins = '{dim_pulse: i_dim_pulse, pwm_gate: i_pwm_gate, supply_low: i_supply_low,
		reg_short: i_reg_short, unity_ok: i_unity_ok};

	// Edge and timeout decode on synchronised levels only
	assign dim_rise = st.sync2.dim_pulse && !st.dim_prev;  // Active-high edge
	assign low_trip = (st.dim_low == SHDN_LAST) || (st.pwm_low == SHDN_LAST);

	////////////////////////////////////////////////////////////////////////////////
	// Next state
	always_comb begin
		next_st          = st;
		next_st.sync1    = pins;  // Sampled every cycle, so 0.2 us phases are never missed
		next_st.sync2    = st.sync1;
		next_st.dim_prev = st.sync2.dim_pulse;

		// Low timers restart whenever their input is seen high
		next_st.dim_low = TIMER_RST;
		next_st.pwm_low = TIMER_RST;
		if (st.enabled && !st.sync2.dim_pulse && st.dim_low != SHDN_LAST) begin
			next_st.dim_low = st.dim_low + 20'h00001;
		end
		if (st.enabled && !st.sync2.pwm_gate && st.pwm_low != SHDN_LAST) begin
			next_st.pwm_low = st.pwm_low + 20'h00001;
		end

		if (st.sync2.supply_low) begin
			next_st.enabled = 1'b0;  // Undervoltage wins over everything
		end else if (st.enabled && low_trip) begin
			next_st.enabled = 1'b0;  // Held low too long
			next_st.dim_low = TIMER_RST;
			next_st.pwm_low = TIMER_RST;
		end else if (!st.enabled && dim_rise) begin
			next_st.enabled = 1'b1;  // First edge enables at full scale
			next_st.count   = ldpc_pkg::COUNT_RST;
		end else if (st.enabled && dim_rise) begin
			next_st.count = st.count + 5'h01;  // 31 wraps to 0 by width
		end

		// Outputs follow the new state so each is a flop with no extra lag
		next_st.level    = ldpc_pkg::LEVEL_FULL - {1'b0, next_st.count};
		next_st.sink_en  = {ldpc_pkg::CHANNELS{next_st.enabled && st.sync2.pwm_gate}};
		next_st.sink_hiz = {ldpc_pkg::CHANNELS{!next_st.enabled}};
	end

	////////////////////////////////////////////////////////////////////////////////
	// State register
	always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
		if (!i_rst_n) begin
			st          <= '0;
			st.level    <= ldpc_pkg::LEVEL_FULL;
			st.sink_hiz <= '1;
		end else begin
			st <= next_st;
		end
	end

	assign o_enabled  = st.enabled;
	assign o_level    = st.level;
	assign o_sink_en  = st.sink_en;
	assign o_sink_hiz = st.sink_hiz;

	////////////////////////////////////////////////////////////////////////////////
	// Charge pump gain sequencing
	ldpc_pump_seq #(
		.P_DWELL     (P_PUMP_DWELL)
	) u_pump (
		.i_clk_sys   (i_clk_sys),
		.i_rst_n     (i_rst_n),
		.i_run       (st.enabled),
		.i_reg_short (st.sync2.reg_short),
		.i_unity_ok  (st.sync2.unity_ok),
		.o_mode      (o_pump_mode)
	);

	////////////////////////////////////////////////////////////////////////////////
	// Checks
	default clocking cb @(posedge i_clk_sys); endclocking
	default disable iff (!i_rst_n);

	a_uvlo_shutdown: assert property (st.sync2.supply_low |=> !o_enabled && o_sink_en == '0)
		else $error("sinks not off under undervoltage");
	a_enable_full: assert property (!o_enabled && dim_rise && !st.sync2.supply_low
		|=> o_enabled && o_level == ldpc_pkg::LEVEL_FULL)
		else $error("enable did not give full scale");
	a_count_step: assert property (o_enabled && dim_rise && !low_trip && !st.sync2.supply_low
		|=> st.count == $past(st.count) + 5'h01 && o_level == 6'h20 - {1'b0, st.count})
		else $error("pulse did not step the level");
	a_count_wrap: assert property (o_enabled && st.count == ldpc_pkg::COUNT_LAST && dim_rise
		&& !low_trip && !st.sync2.supply_low |=> o_level == ldpc_pkg::LEVEL_FULL)
		else $error("level did not wrap to full scale");
	a_count_clear: assert property ($rose(o_enabled) |-> st.count == ldpc_pkg::COUNT_RST)
		else $error("count not cleared on enable");
	a_pwm_zero: assert property ((!i_pwm_gate) [*4] |-> o_sink_en == '0)
		else $error("sinks on while pwm low");
	a_pwm_pass: assert property (o_enabled && st.sync2.pwm_gate ##1 o_enabled
		|-> o_sink_en == '1)
		else $error("sinks off while pwm high");
	a_low_timeout: assert property (o_enabled && low_trip |=> !o_enabled)
		else $error("no shutdown after low timeout");
	a_shdn_hiz: assert property (!o_enabled |-> o_sink_hiz == '1 && o_sink_en == '0)
		else $error("sinks driven in shutdown");
	a_timer_restart: assert property (st.sync2.dim_pulse |=> st.dim_low == TIMER_RST)
		else $error("dim low timer not restarted");

	c_enable: cover property ($rose(o_enabled));
	c_wrap: cover property (o_enabled && st.count == ldpc_pkg::COUNT_LAST ##[1:200] st.count == 5'h00);
	c_timeout: cover property ($fell(o_enabled) && !$past(st.sync2.supply_low));

endmodule

//--- testbench/ldpc_host_model.sv
// Host model that drives the dimming pulse pin and the PWM gate pin.
// Assumes the bench calls its tasks one at a time from a single process, just after i_clk_sys.
module ldpc_host_model (
	input  wire logic i_clk_sys,
	output logic      o_dim_pulse,
	output logic      o_pwm_gate
);
	timeunit 1ns;
	timeprecision 1ps;

	////////////////////////////////////////////////////////////////////////////////
	// Both pins idle low, as the pins' pull-downs would hold them
	initial begin
		o_dim_pulse = 1'b0;
		o_pwm_gate  = 1'b0;
	end

	// One dimming pulse; both phases are stretched to 8 cycles, 0.2 us, at least
	task automatic dim_pulse(input int unsigned hi, input int unsigned lo);
		if (hi < 8) hi = 8;
		if (lo < 8) lo = 8;
		o_dim_pulse <= 1'b1; // Active high pulse
		repeat (hi) @(posedge i_clk_sys);
		o_dim_pulse <= 1'b0;
		repeat (lo) @(posedge i_clk_sys);
	endtask

	// PWM gate level, active high
	task automatic set_pwm(input logic lvl);
		o_pwm_gate <= lvl;
	endtask
endmodule

//--- testbench/ldpc_top_bench.sv
// Self-checking bench for ldpc_top with a host model on the pins.
// Assumes short timing parameters so that the shutdown timeout takes 200 cycles.
module ldpc_top_bench;
	timeunit 1ns;
	timeprecision 1ps;

	localparam int unsigned SHDN = 200;
	logic                      clk;
	logic                      rst_n;
	logic                      supply_low;
	logic                      reg_short;
	logic                      unity_ok;
	logic                      dim;
	logic                      pwm;
	logic                      enabled;
	logic [5:0]                level;
	logic [5:0]                sink_en;
	logic [5:0]                sink_hiz;
	ldpc_pkg::ldpc_pump_mode_t mode;
	logic [6:0]                note_q[$];
	ldpc_pkg::ldpc_pump_mode_t mode_q[$];
	logic [6:0]                last_note;
	ldpc_pkg::ldpc_pump_mode_t last_mode;
	logic                      watch;
	int unsigned               fails;
	int unsigned               checks_done;

	////////////////////////////////////////////////////////////////////////////////
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end

	ldpc_host_model i_host (.i_clk_sys(clk), .o_dim_pulse(dim), .o_pwm_gate(pwm));

	ldpc_top #(.P_SHDN_CYCLES(SHDN), .P_PUMP_DWELL(4)) i_dut (
		.i_clk_sys(clk), .i_rst_n(rst_n), .i_dim_pulse(dim), .i_pwm_gate(pwm),
		.i_supply_low(supply_low), .i_reg_short(reg_short), .i_unity_ok(unity_ok),
		.o_enabled(enabled), .o_level(level), .o_sink_en(sink_en),
		.o_sink_hiz(sink_hiz), .o_pump_mode(mode));

	////////////////////////////////////////////////////////////////////////////////
	task automatic final_report();
		$display("Checks %0d, mismatches %0d", checks_done, fails);
		if (fails == 0 && checks_done > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask

	task automatic chk_note(input logic [6:0] exp, input logic [6:0] got);
		checks_done++;
		if (got !== exp) begin
			fails++;
			$display("[ERR] enable_level exp %h got %h", exp, got);
		end
	endtask

	task automatic chk_mode(input ldpc_pkg::ldpc_pump_mode_t exp, input ldpc_pkg::ldpc_pump_mode_t got);
		checks_done++;
		if (got !== exp) begin
			fails++;
			$display("[ERR] pump_mode exp %h got %h", exp, got);
		end
	endtask

	task automatic chk_vec(input string name, input logic [5:0] exp, input logic [5:0] got);
		checks_done++;
		if (got !== exp) begin
			fails++;
			$display("[ERR] %s exp %h got %h", name, exp, got);
		end
	endtask

	// Waits land one ns past the edge so that the edge's own updates are settled
	task automatic wait_cyc(input int unsigned n);
		repeat (n) @(posedge clk);
		#1;
	endtask

	// Ends one ns past the edge so that following checks see settled outputs
	task automatic pulse();
		i_host.dim_pulse(8 + $urandom % 8, 8 + $urandom % 8);
		#1;
	endtask

	// Level is only meaningful while enabled, so the watched key masks it otherwise
	always @(posedge clk) begin
		logic [6:0] cur;
		cur = {enabled, enabled ? level : 6'h00};
		if (watch && cur !== last_note) begin
			chk_note(note_q.size() ? note_q.pop_front() : 7'h7f, cur);
			last_note = cur;
		end
		if (watch && mode !== last_mode) begin
			chk_mode(mode_q.size() ? mode_q.pop_front() : ldpc_pkg::LDPC_PUMP_1X, mode);
			last_mode = mode;
		end
	end

	// A hang is cut short and counted as a mismatch
	initial begin
		repeat (8000) @(posedge clk);
		fails++;
		$display("[ERR] run_timeout exp done got hang");
		final_report();
	end

	////////////////////////////////////////////////////////////////////////////////
	initial begin
		rst_n = 1'b0;
		supply_low = 1'b0;
		reg_short = 1'b0;
		unity_ok = 1'b1;
		watch = 1'b0;
		fails = 0;
		checks_done = 0;
		last_note = 7'h00;
		last_mode = ldpc_pkg::LDPC_PUMP_1X;
		void'($urandom(79));
		i_host.set_pwm(1'b1);
		wait_cyc(16);
		rst_n <= 1'b1;
		watch <= 1'b1;
		wait_cyc(1);
		chk_vec("hiz", 6'h3f, sink_hiz);
		chk_mode(ldpc_pkg::LDPC_PUMP_1X, mode);
		// Enable, walk all levels, wrap, then one more step
		for (int n = 0; n <= 33; n++) begin
			note_q.push_back({1'b1, (n % 32 == 0) ? 6'h20 : 6'(32 - n % 32)});
			// Random regulation reports must not move the pump while unity is fine
			reg_short <= 1'($urandom % 2);
			pulse();
		end
		reg_short <= 1'b0;
		chk_vec("hiz", 6'h00, sink_hiz);
		chk_vec("sink_on", 6'h3f, sink_en);
		i_host.set_pwm(1'b0);
		wait_cyc(4);
		chk_vec("sink_off", 6'h00, sink_en);
		i_host.set_pwm(1'b1);
		wait_cyc(4);
		chk_vec("sink_on", 6'h3f, sink_en);
		// Pump steps up one gain at a time, then drops straight to unity
		mode_q = '{ldpc_pkg::LDPC_PUMP_1X33, ldpc_pkg::LDPC_PUMP_1X5, ldpc_pkg::LDPC_PUMP_2X,
			ldpc_pkg::LDPC_PUMP_1X};
		reg_short <= 1'b1;
		unity_ok <= 1'b0;
		wait_cyc(40);
		chk_mode(ldpc_pkg::LDPC_PUMP_2X, mode);
		reg_short <= 1'b0;
		unity_ok <= 1'b1;
		wait_cyc(8);
		chk_mode(ldpc_pkg::LDPC_PUMP_1X, mode);
		// Dimming pin held low: still on well before the timeout, off after it
		note_q.push_back(7'h00);
		wait_cyc(60);
		chk_vec("enabled", 6'h01, {5'h00, enabled});
		wait_cyc(90);
		chk_vec("enabled", 6'h00, {5'h00, enabled});
		chk_vec("hiz", 6'h3f, sink_hiz);
		chk_vec("sink_off", 6'h00, sink_en);
		// Re-enable restarts the count from zero
		note_q.push_back({1'b1, 6'h20});
		pulse();
		note_q.push_back({1'b1, 6'h1f});
		pulse();
		// PWM held low while dimming is held high
		note_q.push_back({1'b1, 6'h1e});
		note_q.push_back(7'h00);
		i_host.set_pwm(1'b0);
		i_host.dim_pulse(SHDN + 10, 8);
		wait_cyc(0);
		chk_vec("enabled", 6'h00, {5'h00, enabled});
		i_host.set_pwm(1'b1);
		// Undervoltage shuts down and blocks dimming edges
		note_q.push_back({1'b1, 6'h20});
		pulse();
		note_q.push_back(7'h00);
		supply_low <= 1'b1;
		wait_cyc(8);
		chk_vec("enabled", 6'h00, {5'h00, enabled});
		pulse();
		supply_low <= 1'b0;
		for (int i = 0; i < 50 && (note_q.size() + mode_q.size()) > 0; i++) wait_cyc(1);
		if ((note_q.size() + mode_q.size()) > 0) begin
			fails++;
			$display("[ERR] pending_results exp 0 got %0d", note_q.size() + mode_q.size());
		end
		final_report();
	end
endmodule
